/* File: bench/dsbs_latch_rx.sv */
// External digit latch and busy-gated pulse counter
`timescale 1ns/1ps
module dsbs_latch_rx (
  input wire logic pclk,
  input wire logic strobe_n,
  input wire logic busy,
  input wire logic [4:0] sel,
  input wire logic [3:0] bcd,
  output logic [19:0] digits,
  output int n_strobes,
  output int busy_clocks
);
  logic sq = 1'b1;
  initial begin
    digits = 20'h00000;
    n_strobes = 0;
    busy_clocks = 0;
  end
  // ----------------
  // Capture
  // ----------------
  always @(posedge pclk) begin
    sq <= strobe_n;
    // Latch mid digit, where select and bits are settled
    if (sq && !strobe_n) begin
      n_strobes <= n_strobes + 1;
      for (int i = 0; i < 5; i++) begin
        if (sel[i])
          digits[i*4 +: 4] <= bcd;
      end
    end
    if (busy)
      busy_clocks <= busy_clocks + 1;
  end
endmodule

/* File: bench/dsbs_sequencer_asserts.sv */
// Concurrent checks on the converter sequencer outputs
`timescale 1ns/1ps
module dsbs_chk import dsbs_pkg::*; #(
  parameter int TICK_DIV = TICK_DIV_DEF,
  parameter int INT_LEN = INT_COUNTS,
  parameter int DE_MAX = DE_LIMIT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic busy,
  input wire logic overrange,
  input wire logic underrange,
  input wire logic sign_pos,
  input wire logic strobe_n,
  input wire logic digit_select_msd,
  input wire logic digit_select_fourth,
  input wire logic digit_select_third,
  input wire logic digit_select_second,
  input wire logic digit_select_lsd,
  input wire logic decimal_bit_eight,
  input wire logic decimal_bit_four,
  input wire logic decimal_bit_two,
  input wire logic decimal_bit_one
);
  // ----------------
  // Helper counters
  // ----------------
  logic [4:0] sel;
  logic [3:0] bcd;
  logic sq;
  int gap;
  int low_len;
  int busy_len;
  int idle_len;
  assign sel = {digit_select_msd, digit_select_fourth, digit_select_third,
    digit_select_second, digit_select_lsd};
  assign bcd = {decimal_bit_eight, decimal_bit_four, decimal_bit_two, decimal_bit_one};
  // Strobe spacing measured fall to fall; select edges are unreliable across a rescan
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sq <= 1'b1;
      gap <= 0;
      low_len <= 0;
      busy_len <= 0;
      idle_len <= 0;
    end else begin
      sq <= strobe_n;
      gap <= (sq && !strobe_n) ? 1 : gap + 1;
      low_len <= strobe_n ? 0 : low_len + 1;
      busy_len <= busy ? busy_len + 1 : 0;
      idle_len <= busy ? 0 : idle_len + 1;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------
  // Properties
  // ----------------
  sequence s_strobe_fall;
    $fell(strobe_n);
  endsequence
  sequence s_busy_end;
    $fell(busy);
  endsequence
  a_strobe_in_digit: assert property (!strobe_n |-> $onehot(sel))
    else $error("strobe outside a digit select");
  a_strobe_width: assert property ($rose(strobe_n) |-> low_len == TICK_DIV / 2)
    else $error("strobe width wrong");
  a_strobe_gap: assert property (s_strobe_fall ##0 !sel[4] |-> gap == 200 * TICK_DIV)
    else $error("strobe spacing wrong");
  // Latch one count after busy, msd one count later, then 101 counts
  a_first_strobe: assert property (s_strobe_fall ##0 sel[4] |->
    idle_len == 103 * TICK_DIV)
    else $error("first strobe timing wrong");
  a_select_onehot: assert property ($onehot0(sel))
    else $error("more than one digit selected");
  a_bcd_with_digit: assert property ($changed(bcd) |-> $changed(sel))
    else $error("digit bits changed without select");
  a_busy_span: assert property (s_busy_end |-> busy_len >= (INT_LEN + 1) * TICK_DIV
    && busy_len <= (INT_LEN + DE_MAX + 2) * TICK_DIV)
    else $error("busy length out of bounds");
  a_over_when_idle: assert property ($rose(overrange) |-> !busy)
    else $error("overrange set while busy");
  a_over_clear_ref: assert property ($fell(overrange) |-> busy && $past(busy, 8))
    else $error("overrange cleared outside reference");
  a_under_clear: assert property ($fell(underrange) |-> busy && !$past(busy, 8))
    else $error("underrange cleared outside integrate start");
  a_sign_in_busy: assert property ($changed(sign_pos) |-> busy)
    else $error("sign changed while idle");
endmodule
bind dsbs_sequencer dsbs_chk #(.TICK_DIV(TICK_DIV), .INT_LEN(INT_LEN), .DE_MAX(DE_MAX)) u_chk (
  .pclk, .presetn, .busy, .overrange, .underrange, .sign_pos, .strobe_n, .digit_select_msd,
  .digit_select_fourth, .digit_select_third, .digit_select_second, .digit_select_lsd,
  .decimal_bit_eight, .decimal_bit_four, .decimal_bit_two, .decimal_bit_one);

/* File: bench/tb_dual_slope_bcd_output_sequencer.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_dual_slope_bcd_output_sequencer;
  import dsbs_pkg::*;
  localparam int TD = 4;
  localparam int CL = 1200;
  localparam int IL = 100;
  localparam int DM = 201;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic run_hold = 1'b1;
  logic comp_above = 1'b1;
  logic pos_in = 1'b1;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, busy, overrange, underrange, sign_pos, strobe_n;
  logic [4:0] sel;
  logic [3:0] bcd;
  logic [19:0] digits;
  int n_strobes, busy_clocks;
  int bcnt = 0;
  int cross_at = 0;
  int n_errors = 0;
  int checked = 0;
  always #25 pclk = ~pclk;
  dsbs_sequencer #(.TICK_DIV(TD), .CYCLE_LEN(CL), .INT_LEN(IL), .DE_MAX(DM), .ZI_LONG(620)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .run_hold, .comp_above, .busy, .overrange, .underrange, .sign_pos, .strobe_n,
    .digit_select_msd(sel[4]), .digit_select_fourth(sel[3]), .digit_select_third(sel[2]),
    .digit_select_second(sel[1]), .digit_select_lsd(sel[0]), .decimal_bit_eight(bcd[3]),
    .decimal_bit_four(bcd[2]), .decimal_bit_two(bcd[1]), .decimal_bit_one(bcd[0]));
  dsbs_latch_rx rx (.pclk, .strobe_n, .busy, .sel, .bcd, .digits, .n_strobes, .busy_clocks);
  // Integrator crosses zero mid count, so the reading may round either way
  always @(posedge pclk) begin
    bcnt <= busy ? bcnt + 1 : 0;
    comp_above <= (busy && bcnt >= cross_at) ? !pos_in : pos_in;
  end
  // ----------------
  // Shared tasks
  // ----------------
  task automatic final_report;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic timeout;
    n_errors++;
    $display("timeout at %0t", $time);
    final_report;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      timeout;
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    for (int i = 0; i < lim && busy !== lvl; i++) @(posedge pclk);
    if (busy !== lvl)
      timeout;
  endtask
  task automatic wait_strobes(input int n);
    for (int i = 0; i < 1200 * TD && n_strobes < n; i++) @(posedge pclk);
    if (n_strobes < n)
      timeout;
  endtask
  task automatic pulse_run;
    run_hold <= 1'b1;
    repeat (8) @(posedge pclk);
    run_hold <= 1'b0;
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_regs;
    apb(1'b0, STATUS_ADDR, 32'h0);
    cmp({27'h0, err, rd[11:8]}, 32'h1);
    apb(1'b1, CTRL_ADDR, 32'h1);
    apb(1'b0, CTRL_ADDR, 32'h0);
    cmp(rd, 32'h1);
    apb(1'b1, CTRL_ADDR, 32'h0);
    apb(1'b1, 8'h0C, 32'hFFFFFFFF);
    cmp(32'(err), 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    cmp(rd, 32'h0);
  endtask
  task automatic t_free_run;
    longint t0;
    int s0;
    cross_at <= (IL + 50) * TD + TD / 2;
    wait_busy(1'b1, CL * TD + 100);
    t0 = $time;
    s0 = n_strobes;
    wait_busy(1'b0, (IL + DM + 4) * TD);
    repeat (3 * TD) @(posedge pclk);
    cmp({29'h0, overrange, underrange, sign_pos}, 32'h3);
    apb(1'b0, RESULT_ADDR, 32'h0);
    cmp(32'(rd[19:0] inside {20'h00050, 20'h00051}), 32'h1);
    wait_strobes(s0 + 5);
    cmp({11'h0, 1'b1, digits}, rd);
    wait_busy(1'b1, CL * TD);
    cmp(32'($time - t0), 32'(CL * TD * 50));
    cmp(32'(n_strobes - s0), 32'h5);
  endtask
  task automatic t_negative;
    pos_in <= 1'b0;
    wait_busy(1'b0, (IL + DM + 4) * TD);
    repeat (3 * TD) @(posedge pclk);
    apb(1'b0, RESULT_ADDR, 32'h0);
    cmp({30'h0, sign_pos, rd[20]}, 32'h0);
  endtask
  task automatic t_over;
    int s0;
    int b0;
    pos_in <= 1'b1;
    cross_at <= 1000000;
    wait_busy(1'b1, CL * TD + 100);
    run_hold <= 1'b0;
    s0 = n_strobes;
    wait_busy(1'b0, (IL + DM + 4) * TD);
    repeat (3 * TD) @(posedge pclk);
    cmp({29'h0, overrange, underrange, sign_pos}, 32'h5);
    apb(1'b0, RESULT_ADDR, 32'h0);
    cmp(32'(rd[19:0]), 32'h0);
    repeat (400 * TD) @(posedge pclk);
    apb(1'b0, STATUS_ADDR, 32'h0);
    cmp(32'(rd[11:8]), 32'h8);
    wait_strobes(s0 + 5);
    repeat (300 * TD) @(posedge pclk);
    cmp(32'(sel), 32'h0);
    b0 = busy_clocks;
    repeat (2 * CL * TD) @(posedge pclk);
    apb(1'b0, STATUS_ADDR, 32'h0);
    cmp({rd[11:8], 28'(busy_clocks - b0)}, 32'h10000000);
    cmp(32'(n_strobes - s0), 32'h5);
  endtask
  task automatic t_start;
    int b0;
    pulse_run;
    wait_busy(1'b1, 40 * TD);
    repeat ((IL + 3) * TD) @(posedge pclk);
    cmp(32'(overrange), 32'h0);
    pulse_run;
    wait_busy(1'b0, (IL + DM + 4) * TD);
    b0 = busy_clocks;
    repeat (2 * CL * TD) @(posedge pclk);
    cmp(32'(busy_clocks - b0), 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_free_run;
    t_negative;
    t_over;
    t_start;
    final_report;
  end
endmodule

/* File: src/dsbs_pkg.sv */
// Constants, encodings and register map of the dual-slope output sequencer
package dsbs_pkg;
  // ----------------------------------------------------------------
  // Clock and pin timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int PULSE_MIN_NS = 300;
  // Least pulse time, rounded up to whole clock cycles
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Run level must stand this long before it counts
  localparam int RUN_FILT_CYC = PULSE_MIN_CYC / 2;
  localparam int TICK_DIV_DEF = 100;
  // ----------------------------------------------------------------
  // Measurement cycle, in converter counts
  // ----------------------------------------------------------------
  localparam int CYCLE_COUNTS = 40002;
  localparam int INT_COUNTS = 10000;
  localparam int DE_LIMIT = 20001;
  localparam int ZI_NORMAL = 200;
  localparam int ZI_OVER = 6200;
  localparam logic [15:0] UNDER_LIMIT_BCD = 16'h1800;
  // ----------------------------------------------------------------
  // Digit scan
  // ----------------------------------------------------------------
  localparam int DIGITS = 5;
  localparam logic [7:0] MSD_LEN = 8'd201;
  localparam logic [7:0] DIGIT_LEN = 8'd200;
  localparam logic [7:0] STROBE_AT = 8'd100;
  localparam logic [2:0] LSD_IDX = 3'd4;
  // ----------------------------------------------------------------
  // Register map (APB, byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] RESULT_ADDR = 8'h08;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_OVER_BIT = 1;
  localparam int ST_UNDER_BIT = 2;
  localparam int ST_SIGN_BIT = 3;
  localparam int ST_WAIT_BIT = 4;
  localparam int ST_PHASE_LSB = 8;
  localparam int RES_SIGN_BIT = 20;
  // ----------------------------------------------------------------
  // Phases, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    offset_null_phase = 4'b0001,
    signal_int_phase = 4'b0010,
    reference_integrate_phase = 4'b0100,
    integrator_reset_phase = 4'b1000
  } dsbs_phase_e;
endpackage

/* File: src/dsbs_sequencer.sv */
// Dual-slope converter sequencer with multiplexed decimal output and APB registers
//
// Operation
// - Run high: new cycle every 40002 counts
// - Run low: finish cycle, then hold result
// - Start pulse over 300ns starts new cycle
// - Start before cycle complete is ignored
// - First strobe 101 counts after cycle end
// - Five half-count strobes per new result
// - Msd select 201 counts on first scan after new result, others 200
// - Scan continues, strobes stop until new result
// - Busy from integrate to crossing or end
// - Result latches load one count after busy
// - Not busy means reset or null phases
// - Overrange set at busy end, cleared at reference
// - Underrange set at busy end, cleared at integrate
// - Sign valid from reference integrate onward
// - Digit selects scanned msd to lsd continuously
// - Overrange blanks selects until reference integrate
// - Decimal bits change with digit select
// - Phases: null, integrate, reference, reset
// - Reset phase 200 counts, 6200 after overrange
// - Counter held one count at reference, null
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module dsbs_sequencer import dsbs_pkg::*; #(
  parameter int TICK_DIV = TICK_DIV_DEF,
  parameter int CYCLE_LEN = CYCLE_COUNTS,
  parameter int INT_LEN = INT_COUNTS,
  parameter int DE_MAX = DE_LIMIT,
  parameter int ZI_LONG = ZI_OVER
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic run_hold,
  input wire logic comp_above,
  output logic busy,
  output logic overrange,
  output logic underrange,
  output logic sign_pos,
  output logic strobe_n,
  output logic digit_select_msd,
  output logic digit_select_fourth,
  output logic digit_select_third,
  output logic digit_select_second,
  output logic digit_select_lsd,
  output logic decimal_bit_eight,
  output logic decimal_bit_four,
  output logic decimal_bit_two,
  output logic decimal_bit_one
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam logic [15:0] CYC_END = 16'(CYCLE_LEN - 1);
  localparam logic [15:0] INT_END = 16'(INT_LEN - 1);
  localparam logic [15:0] DE_END = 16'(INT_LEN + DE_MAX - 1);
  localparam logic [15:0] ZI_SHORT_END = 16'(ZI_NORMAL - 1);
  localparam logic [15:0] ZI_LONG_END = 16'(ZI_LONG - 1);
  localparam logic [15:0] DIV_END = 16'(TICK_DIV - 1);
  localparam logic [15:0] HALF_LEN = 16'(TICK_DIV / 2);
  localparam logic [2:0] FILT_END = 3'(RUN_FILT_CYC);

  function automatic logic [19:0] bcd_inc(input logic [19:0] v);
    logic [19:0] r;
    logic carry;
    r = v;
    carry = 1'b1;
    for (int i = 0; i < DIGITS; i++) begin
      if (carry) begin
        if (r[4*i +: 4] == 4'h9) begin
          r[4*i +: 4] = 4'h0;
        end else begin
          r[4*i +: 4] = r[4*i +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] digit_of(input logic [19:0] v, input logic [2:0] idx);
    // Index 0 is the most significant digit
    return v[4*(LSD_IDX - idx) +: 4];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and count divider
  // ----------------------------------------------------------------
  logic rh_s1, rh_s2, rh_s3, cp_s1, cp_s2, cp_s3;
  logic run_lvl, next_run_lvl, comp_lvl, next_comp_lvl, tick, next_tick;
  logic [2:0] filt, next_filt;
  logic [15:0] div_cnt, next_div_cnt;

  always_comb begin
    next_filt = filt;
    next_run_lvl = run_lvl;
    // Filter stops sub-pulse noise yet passes any 300ns pulse
    if (rh_s2 != rh_s3 || rh_s3 == run_lvl) begin
      next_filt = 3'h0;
    end else if (filt == FILT_END) begin
      next_run_lvl = rh_s3;
    end else begin
      next_filt = filt + 3'h1;
    end
    next_comp_lvl = (cp_s2 == cp_s3) ? cp_s3 : comp_lvl;
    next_tick = (div_cnt == DIV_END);
    next_div_cnt = next_tick ? 16'h0000 : div_cnt + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rh_s1, rh_s2, rh_s3, cp_s1, cp_s2, cp_s3} <= 6'h00;
      run_lvl <= 1'b0;
      comp_lvl <= 1'b0;
      filt <= 3'h0;
      tick <= 1'b0;
      div_cnt <= 16'h0000;
    end else begin
      {rh_s1, rh_s2, rh_s3} <= {run_hold, rh_s1, rh_s2};
      {cp_s1, cp_s2, cp_s3} <= {comp_above, cp_s1, cp_s2};
      run_lvl <= next_run_lvl;
      comp_lvl <= next_comp_lvl;
      filt <= next_filt;
      tick <= next_tick;
      div_cnt <= next_div_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------
  dsbs_phase_e phase, next_phase;
  logic [15:0] cyc, next_cyc, zi_cnt, next_zi_cnt;
  logic [19:0] res, next_res, res_lat, next_res_lat;
  logic holdoff, next_holdoff, comp_q, next_comp_q, start_req, next_start_req;
  logic ov_now, next_ov_now, latch_pend, next_latch_pend, new_res, next_new_res;
  logic next_busy, next_over, next_under, next_sign, soft_hold, ref_start;
  logic waiting;

  assign waiting = (phase == offset_null_phase) && (cyc == CYC_END);

  always_comb begin
    next_phase = phase;
    next_cyc = cyc;
    next_zi_cnt = zi_cnt;
    next_res = res;
    next_res_lat = res_lat;
    next_holdoff = holdoff;
    next_comp_q = comp_q;
    next_ov_now = ov_now;
    next_latch_pend = latch_pend;
    // Held until the scan's next tick takes it
    next_new_res = tick ? 1'b0 : new_res;
    next_busy = busy;
    next_over = overrange;
    next_under = underrange;
    next_sign = sign_pos;
    ref_start = 1'b0;
    // Pulse taken only once the full cycle is done
    next_start_req = waiting ? (start_req | (run_lvl & ~soft_hold)) : 1'b0;
    if (tick) begin
      next_comp_q = comp_lvl;
      if (phase != offset_null_phase || cyc != CYC_END) begin
        next_cyc = cyc + 16'h0001;
      end
      if (latch_pend) begin
        next_latch_pend = 1'b0;
        next_res_lat = ov_now ? 20'h00000 : res;
        next_over = ov_now;
        next_under = ~ov_now && (res[19:16] == 4'h0) && (res[15:0] <= UNDER_LIMIT_BCD);
        next_new_res = 1'b1;
      end
      case (phase)
        offset_null_phase: begin
          next_res = 20'h00000; // Counter held off through null
          if (cyc == CYC_END && start_req) begin
            // Free-run wraps here; a held converter waits here
            next_start_req = 1'b0;
            next_cyc = 16'h0000;
            next_phase = signal_int_phase;
            next_busy = 1'b1;
            next_under = 1'b0;
          end
        end
        signal_int_phase: begin
          if (cyc == INT_END) begin
            next_phase = reference_integrate_phase;
            next_sign = comp_lvl; // Zero still reads positive
            next_over = 1'b0;
            next_holdoff = 1'b1;
            next_ov_now = 1'b0;
            ref_start = 1'b1;
          end
        end
        reference_integrate_phase: begin
          if (holdoff) begin
            next_holdoff = 1'b0; // Covers comparator flop delay
          end else if (comp_q != sign_pos) begin
            next_busy = 1'b0; // Crossing ends busy
            next_latch_pend = 1'b1;
            next_phase = integrator_reset_phase;
            next_zi_cnt = 16'h0000;
          end else if (cyc == DE_END) begin
            next_busy = 1'b0; // Limit reached, overrange
            next_ov_now = 1'b1;
            next_latch_pend = 1'b1;
            next_phase = integrator_reset_phase;
            next_zi_cnt = 16'h0000;
          end else begin
            next_res = bcd_inc(res);
          end
        end
        integrator_reset_phase: begin
          next_zi_cnt = zi_cnt + 16'h0001;
          if (zi_cnt == (ov_now ? ZI_LONG_END : ZI_SHORT_END)) begin
            next_phase = offset_null_phase; // Back to null
          end
        end
        default: begin
          next_phase = offset_null_phase;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= offset_null_phase;
      cyc <= 16'h0000;
      zi_cnt <= 16'h0000;
      res <= 20'h00000;
      res_lat <= 20'h00000;
      {holdoff, comp_q, start_req, ov_now, latch_pend, new_res} <= 6'h00;
      {busy, overrange, underrange, sign_pos} <= 4'h0;
    end else begin
      phase <= next_phase;
      cyc <= next_cyc;
      zi_cnt <= next_zi_cnt;
      res <= next_res;
      res_lat <= next_res_lat;
      {holdoff, comp_q, start_req} <= {next_holdoff, next_comp_q, next_start_req};
      {ov_now, latch_pend, new_res} <= {next_ov_now, next_latch_pend, next_new_res};
      {busy, overrange, underrange, sign_pos} <= {next_busy, next_over, next_under, next_sign};
    end
  end

  // ----------------------------------------------------------------
  // Digit scan and strobes
  // ----------------------------------------------------------------
  logic [2:0] idx, next_idx, left, next_left;
  logic [7:0] dcnt, next_dcnt;
  logic msd_long, next_msd_long, blank, next_blank, ref_pend, next_ref_pend;
  logic [15:0] stb_cnt, next_stb_cnt;
  logic next_strobe_n;
  logic [4:0] dsel, next_dsel;
  logic [3:0] bcd, next_bcd;

  always_comb begin
    next_idx = idx;
    next_left = left;
    next_dcnt = dcnt;
    next_msd_long = msd_long;
    next_blank = blank;
    next_stb_cnt = stb_cnt;
    next_strobe_n = strobe_n;
    // Reference start comes from the tick before; carry it one tick
    next_ref_pend = ref_pend;
    if (stb_cnt != 16'h0000) begin
      next_stb_cnt = stb_cnt - 16'h0001;
      next_strobe_n = (stb_cnt == 16'h0001); // Low half a count
    end
    if (tick) begin
      next_ref_pend = ref_start;
      if (new_res) begin
        next_idx = 3'h0; // Msd rises at cycle end
        next_dcnt = 8'h00;
        next_left = 3'(DIGITS);
        next_msd_long = 1'b1;
        next_blank = 1'b0;
      end else if (blank) begin
        if (ref_pend) begin
          next_blank = 1'b0; // Restart at msd
          next_idx = 3'h0;
          next_dcnt = 8'h00;
        end
      end else begin
        next_dcnt = dcnt + 8'h01;
        if (left != 3'h0 && dcnt == STROBE_AT - 8'h01 + {7'h00, msd_long}) begin
          next_left = left - 3'h1; // Centred strobe
          next_stb_cnt = HALF_LEN;
          next_strobe_n = 1'b0;
        end
        if (dcnt == (msd_long ? MSD_LEN : DIGIT_LEN) - 8'h01) begin
          next_dcnt = 8'h00;
          next_msd_long = 1'b0;
          next_idx = (idx == LSD_IDX) ? 3'h0 : idx + 3'h1;
          // Blank after the strobe run on overrange
          if (idx == LSD_IDX && left == 3'h0 && overrange) begin
            next_blank = 1'b1;
          end
        end
      end
    end
    next_dsel = dsel;
    next_bcd = bcd;
    // Bits move only with the select, so a new result never flips them mid digit
    if (tick) begin
      next_dsel = next_blank ? 5'h00 : 5'(5'h10 >> next_idx);
      next_bcd = next_blank ? 4'h0 : digit_of(res_lat, next_idx);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx <= 3'h0;
      left <= 3'h0;
      dcnt <= 8'h00;
      {msd_long, blank, ref_pend} <= 3'h0;
      stb_cnt <= 16'h0000;
      strobe_n <= 1'b1;
      dsel <= 5'h00;
      bcd <= 4'h0;
    end else begin
      idx <= next_idx;
      left <= next_left;
      dcnt <= next_dcnt;
      {msd_long, blank, ref_pend} <= {next_msd_long, next_blank, next_ref_pend};
      stb_cnt <= next_stb_cnt;
      strobe_n <= next_strobe_n;
      dsel <= next_dsel;
      bcd <= next_bcd;
    end
  end

  assign {digit_select_msd, digit_select_fourth, digit_select_third} = dsel[4:2];
  assign {digit_select_second, digit_select_lsd} = dsel[1:0];
  assign {decimal_bit_eight, decimal_bit_four, decimal_bit_two, decimal_bit_one} = bcd;

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  logic [31:0] next_prdata;
  logic next_pslverr, next_soft_hold;

  always_comb begin
    next_prdata = prdata;
    next_pslverr = pslverr;
    next_soft_hold = soft_hold;
    if (psel && !penable) begin
      next_prdata = 32'h00000000;
      next_pslverr = 1'b0;
      case (paddr)
        CTRL_ADDR: next_prdata[CTRL_HOLD_BIT] = soft_hold;
        STATUS_ADDR: begin
          next_prdata[ST_BUSY_BIT] = busy;
          next_prdata[ST_OVER_BIT] = overrange;
          next_prdata[ST_UNDER_BIT] = underrange;
          next_prdata[ST_SIGN_BIT] = sign_pos;
          next_prdata[ST_WAIT_BIT] = waiting;
          next_prdata[ST_PHASE_LSB +: 4] = phase;
        end
        RESULT_ADDR: begin
          next_prdata[19:0] = res_lat;
          next_prdata[RES_SIGN_BIT] = sign_pos;
        end
        default: next_pslverr = 1'b1;
      endcase
    end
    // Software hold acts as the run pin held low
    if (psel && penable && pwrite && paddr == CTRL_ADDR) begin
      next_soft_hold = pwdata[CTRL_HOLD_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pready <= 1'b0;
      soft_hold <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= 1'b1;
      soft_hold <= next_soft_hold;
    end
  end
endmodule
